// file: rtl/rgen_pkg.sv
package rgen_pkg;

  // clock and tick timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [3:0] A_TARGET_ONE   = 4'h0;
  localparam logic [3:0] A_TARGET_TWO   = 4'h1;
  localparam logic [3:0] A_CEILING      = 4'h2;
  localparam logic [3:0] A_FLOOR_OFFSET = 4'h3;
  localparam logic [3:0] A_RATE         = 4'h4;
  localparam logic [3:0] A_GAIN         = 4'h5;
  localparam logic [3:0] A_OUT_OFFSET   = 4'h6;
  localparam logic [3:0] A_SOURCE       = 4'h7;
  localparam logic [3:0] A_LEVEL        = 4'h8;
  localparam logic [3:0] A_SCALED       = 4'h9;
  localparam logic [3:0] A_STATE        = 4'hA;

  // source register field positions
  localparam int unsigned SRC_ONE_BIT = 0;
  localparam int unsigned SRC_TWO_BIT = 1;

  // reset values
  localparam logic [15:0] RST_TARGET_ONE   = 16'h0000;
  localparam logic [15:0] RST_TARGET_TWO   = 16'h0000;
  localparam logic [15:0] RST_CEILING      = 16'h4E20;
  localparam logic [15:0] RST_FLOOR_OFFSET = 16'h0000;
  localparam logic [15:0] RST_RATE         = 16'h0064;
  localparam logic [15:0] RST_GAIN         = 16'h0064;
  localparam logic [15:0] RST_OUT_OFFSET   = 16'h0000;
  localparam logic [1:0]  RST_SOURCE       = 2'h0;

  // value limits; gain is held in hundredths
  localparam logic [15:0] RATE_MIN   = 16'h0001;
  localparam logic [15:0] RATE_MAX   = 16'h2710;
  localparam logic [15:0] GAIN_MAX   = 16'h03E8;
  localparam logic [15:0] GAIN_UNITY = 16'h0064;
  localparam logic [15:0] TICKS_PER_S = 16'h000A;
  localparam logic [15:0] AQ_MAX     = 16'h7FFF;

  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_START     = 6'h02,
    ST_RAMP      = 6'h04,
    ST_HALT_RAMP = 6'h08,
    ST_HALT_HOLD = 6'h10,
    ST_LOCKED    = 6'h20
  } rgen_state_e;

  typedef logic signed [17:0] rgen_lvl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } rgen_req_s;

endpackage : rgen_pkg

// file: rtl/rgen_ramp.sv
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] rising enable forces level to floor plus offset, held 100 ms
// [RULE_02] after the start hold, ramp toward the selected target at programmed rate
// [RULE_03] halt ramps down to floor, holds 100 ms, then sets level to offset
// [RULE_04] after a halt, restart only once halt and enable are both cleared
// [RULE_05] a select change ramps from current level toward the new target
// [RULE_06] enable cleared sets level to offset at once, no ramp or hold
// [RULE_07] the level is recomputed once per 100 ms tick
// [RULE_08] scaled output is level minus offset divided by gain
// [RULE_09] each target comes from a constant or from another block's value
// [RULE_10] select 0 picks target one, select 1 picks target two
// [RULE_11] level never exceeds the programmed ceiling
// [RULE_12] rate is steps per second, range 1 to 10000
// [RULE_13] scaled output stays within 0 to 32767
// [RULE_14] each tick moves rate/10 toward target, stopping exactly on it
module rgen_ramp #(
  parameter int unsigned TICK_CYCLES = rgen_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // control inputs
  input  wire logic                 enable,
  input  wire logic                 level_sel,
  input  wire logic                 decelerated_halt,
  // actual values of other blocks
  input  wire logic [15:0]          ext_level_one,
  input  wire logic [15:0]          ext_level_two,
  // register port
  input  wire rgen_pkg::rgen_req_s  req,
  output logic [15:0]               rdata_ff,
  // results
  output logic [15:0]               scaled_analog_out_ff,
  output logic [15:0]               current_level_ff
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 4194304) begin : g_chk
    $error("TICK_CYCLES must lie in 2 to 4194304");
  end

  rgen_pkg::rgen_state_e state_ff;
  rgen_pkg::rgen_state_e nxt_state;
  rgen_pkg::rgen_lvl_t   level_ff;
  rgen_pkg::rgen_lvl_t   nxt_level;
  logic [15:0]           target_one_ff;
  logic [15:0]           target_two_ff;
  logic [15:0]           ceiling_ff;
  logic [15:0]           floor_offset_ff;
  logic [15:0]           rate_ff;
  logic [15:0]           gain_ff;
  logic [15:0]           out_offset_ff;
  logic [1:0]            source_ff;
  logic [21:0]           tick_cnt_ff;
  logic                  tick;
  logic                  restart;
  logic [15:0]           acc_ff;
  logic [15:0]           nxt_acc;
  logic                  enable_d_ff;
  rgen_pkg::rgen_lvl_t   ceil_lvl;
  rgen_pkg::rgen_lvl_t   offset_lvl;
  rgen_pkg::rgen_lvl_t   floor_lvl;
  rgen_pkg::rgen_lvl_t   target_lvl;
  logic [15:0]           sel_one;
  logic [15:0]           sel_two;
  logic [15:0]           step;
  logic [15:0]           acc_sum;
  logic [15:0]           nxt_scaled;

  // sign-extend a 16-bit register value to level width
  function automatic rgen_pkg::rgen_lvl_t sx(input logic [15:0] v);
    sx = {{2{v[15]}}, v};
  endfunction : sx

  // limit a level to the ceiling
  function automatic rgen_pkg::rgen_lvl_t clamp_ceil(input rgen_pkg::rgen_lvl_t v,
                                                    input rgen_pkg::rgen_lvl_t c);
    clamp_ceil = (v > c) ? c : v;
  endfunction : clamp_ceil

  // move cur toward tgt by at most stp, never past it
  function automatic rgen_pkg::rgen_lvl_t step_toward(input rgen_pkg::rgen_lvl_t cur,
                                                     input rgen_pkg::rgen_lvl_t tgt,
                                                     input logic [15:0]         stp);
    rgen_pkg::rgen_lvl_t d;
    d = {2'b00, stp};
    if (cur < tgt) begin
      step_toward = (tgt - cur > d) ? cur + d : tgt;
    end else begin
      step_toward = (cur - tgt > d) ? cur - d : tgt;
    end
  endfunction : step_toward

  // limit a written value to a range
  function automatic logic [15:0] limit(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    limit = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : limit

  assign ceil_lvl   = sx(ceiling_ff);
  assign offset_lvl = sx(out_offset_ff);
  assign floor_lvl  = clamp_ceil(offset_lvl + {2'b00, floor_offset_ff}, ceil_lvl); // RULE_11

  // target sources and selection
  assign sel_one    = source_ff[rgen_pkg::SRC_ONE_BIT] ? ext_level_one : target_one_ff; // RULE_09
  assign sel_two    = source_ff[rgen_pkg::SRC_TWO_BIT] ? ext_level_two : target_two_ff; // RULE_09
  assign target_lvl = clamp_ceil(sx(level_sel ? sel_two : sel_one), ceil_lvl); // RULE_10 RULE_05

  // steps per tick carry a remainder so low rates still move
  assign acc_sum = acc_ff + rate_ff; // RULE_12
  assign step    = acc_sum / rgen_pkg::TICKS_PER_S; // RULE_14

  // tick divider, restarted so each hold lasts one full tick
  assign tick = (tick_cnt_ff == 22'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset || restart || tick) begin
      tick_cnt_ff <= 22'h000000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 22'h000001; // RULE_07
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_d_ff <= 1'b0;
    end else begin
      enable_d_ff <= enable;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_level = level_ff;
    nxt_acc   = acc_ff;
    restart   = 1'b0;
    unique case (state_ff)
      rgen_pkg::ST_IDLE: begin
        nxt_level = offset_lvl;
        if (enable && !enable_d_ff) begin
          nxt_state = rgen_pkg::ST_START;
          nxt_level = floor_lvl; // RULE_01
          nxt_acc   = 16'h0000;
          restart   = 1'b1;
        end
      end
      rgen_pkg::ST_START: begin
        nxt_level = floor_lvl; // RULE_01
        if (tick) begin
          nxt_state = rgen_pkg::ST_RAMP; // RULE_02
        end
      end
      rgen_pkg::ST_RAMP: begin
        if (tick) begin
          nxt_level = step_toward(level_ff, target_lvl, step); // RULE_02 RULE_14
          nxt_acc   = acc_sum - step * rgen_pkg::TICKS_PER_S;
        end
      end
      rgen_pkg::ST_HALT_RAMP: begin
        if (level_ff == floor_lvl) begin
          nxt_state = rgen_pkg::ST_HALT_HOLD; // RULE_03
          restart   = 1'b1;
        end else if (tick) begin
          nxt_level = step_toward(level_ff, floor_lvl, step); // RULE_03
          nxt_acc   = acc_sum - step * rgen_pkg::TICKS_PER_S;
        end
      end
      rgen_pkg::ST_HALT_HOLD: begin
        nxt_level = floor_lvl;
        if (tick) begin
          nxt_state = rgen_pkg::ST_LOCKED;
          nxt_level = offset_lvl; // RULE_03
        end
      end
      rgen_pkg::ST_LOCKED: begin
        nxt_level = offset_lvl;
        if (!enable && !decelerated_halt) begin
          nxt_state = rgen_pkg::ST_IDLE; // RULE_04
        end
      end
      default: begin
        nxt_state = rgen_pkg::ST_IDLE;
        nxt_level = offset_lvl;
      end
    endcase
    // halt request while running starts the decelerated stop
    if (decelerated_halt && (state_ff == rgen_pkg::ST_START || state_ff == rgen_pkg::ST_RAMP)) begin
      nxt_state = rgen_pkg::ST_HALT_RAMP; // RULE_03
      nxt_level = level_ff;
      restart   = 1'b0;
    end
    // enable low overrides everything, no ramp and no hold
    if (!enable && state_ff != rgen_pkg::ST_IDLE) begin
      nxt_level = offset_lvl; // RULE_06
      nxt_state = decelerated_halt ? rgen_pkg::ST_LOCKED : rgen_pkg::ST_IDLE; // RULE_04
      restart   = 1'b0;
    end
    nxt_level = clamp_ceil(nxt_level, ceil_lvl); // RULE_11
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= rgen_pkg::ST_IDLE;
      level_ff <= 18'sh00000;
      acc_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      level_ff <= nxt_level;
      acc_ff   <= nxt_acc;
    end
  end

  // scaled output with gain in hundredths
  always_comb begin
    logic signed [18:0] diff;
    logic [25:0]        quo;
    diff = 19'(level_ff) - 19'(offset_lvl);
    quo  = 26'h0000000;
    if (diff <= 19'sh00000) begin
      nxt_scaled = 16'h0000; // RULE_13
    end else if (gain_ff == 16'h0000) begin
      nxt_scaled = rgen_pkg::AQ_MAX; // RULE_13
    end else begin
      quo        = (26'(diff) * 26'(rgen_pkg::GAIN_UNITY)) / 26'(gain_ff); // RULE_08
      nxt_scaled = (quo > 26'(rgen_pkg::AQ_MAX)) ? rgen_pkg::AQ_MAX : quo[15:0]; // RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scaled_analog_out_ff <= 16'h0000;
      current_level_ff     <= 16'h0000;
    end else begin
      scaled_analog_out_ff <= nxt_scaled;
      current_level_ff     <= level_ff[15:0];
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      target_one_ff   <= rgen_pkg::RST_TARGET_ONE;
      target_two_ff   <= rgen_pkg::RST_TARGET_TWO;
      ceiling_ff      <= rgen_pkg::RST_CEILING;
      floor_offset_ff <= rgen_pkg::RST_FLOOR_OFFSET;
      rate_ff         <= rgen_pkg::RST_RATE;
      gain_ff         <= rgen_pkg::RST_GAIN;
      out_offset_ff   <= rgen_pkg::RST_OUT_OFFSET;
      source_ff       <= rgen_pkg::RST_SOURCE;
    end else if (req.wr) begin
      unique case (req.addr)
        rgen_pkg::A_TARGET_ONE:   target_one_ff   <= req.wdata;
        rgen_pkg::A_TARGET_TWO:   target_two_ff   <= req.wdata;
        rgen_pkg::A_CEILING:      ceiling_ff      <= req.wdata;
        rgen_pkg::A_FLOOR_OFFSET: floor_offset_ff <= req.wdata;
        rgen_pkg::A_RATE:         rate_ff <= limit(req.wdata, rgen_pkg::RATE_MIN,
                                                   rgen_pkg::RATE_MAX); // RULE_12
        rgen_pkg::A_GAIN:         gain_ff <= limit(req.wdata, 16'h0000, rgen_pkg::GAIN_MAX);
        rgen_pkg::A_OUT_OFFSET:   out_offset_ff   <= req.wdata;
        rgen_pkg::A_SOURCE:       source_ff       <= req.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge clk) begin
    if (reset || !req.rd) begin
      rdata_ff <= 16'h0000;
    end else begin
      unique case (req.addr)
        rgen_pkg::A_TARGET_ONE:   rdata_ff <= target_one_ff;
        rgen_pkg::A_TARGET_TWO:   rdata_ff <= target_two_ff;
        rgen_pkg::A_CEILING:      rdata_ff <= ceiling_ff;
        rgen_pkg::A_FLOOR_OFFSET: rdata_ff <= floor_offset_ff;
        rgen_pkg::A_RATE:         rdata_ff <= rate_ff;
        rgen_pkg::A_GAIN:         rdata_ff <= gain_ff;
        rgen_pkg::A_OUT_OFFSET:   rdata_ff <= out_offset_ff;
        rgen_pkg::A_SOURCE:       rdata_ff <= {14'h0000, source_ff};
        rgen_pkg::A_LEVEL:        rdata_ff <= level_ff[15:0];
        rgen_pkg::A_SCALED:       rdata_ff <= scaled_analog_out_ff;
        rgen_pkg::A_STATE:        rdata_ff <= {10'h000, state_ff};
        default:                  rdata_ff <= 16'h0000;
      endcase
    end
  end

  // checks
  a_start_floor: assert property (@(posedge clk) disable iff (reset) // RULE_01
    (state_ff == rgen_pkg::ST_START) |-> (level_ff == $past(floor_lvl)))
    else $error("level not at floor during start hold");

  a_start_ramp: assert property (@(posedge clk) disable iff (reset) // RULE_02
    (state_ff == rgen_pkg::ST_START && tick && enable && !decelerated_halt)
      |=> (state_ff == rgen_pkg::ST_RAMP))
    else $error("start hold did not end in ramp");

  a_halt_end: assert property (@(posedge clk) disable iff (reset) // RULE_03
    (state_ff == rgen_pkg::ST_HALT_HOLD && tick && enable)
      |=> (state_ff == rgen_pkg::ST_LOCKED && level_ff == $past(clamp_ceil(offset_lvl, ceil_lvl))))
    else $error("halt hold did not end at offset");

  a_lock_stay: assert property (@(posedge clk) disable iff (reset) // RULE_04
    (state_ff == rgen_pkg::ST_LOCKED && (enable || decelerated_halt))
      |=> (state_ff == rgen_pkg::ST_LOCKED))
    else $error("left lock before inputs cleared");

  a_disable_off: assert property (@(posedge clk) disable iff (reset) // RULE_06
    (!enable) |=> (level_ff == $past(clamp_ceil(offset_lvl, ceil_lvl))))
    else $error("level not at offset after disable");

  a_tick_only: assert property (@(posedge clk) disable iff (reset) // RULE_07
    (state_ff == rgen_pkg::ST_RAMP && !tick && enable && !decelerated_halt && level_ff <= ceil_lvl)
      |=> $stable(level_ff))
    else $error("level moved between ticks");

  a_ceiling_cap: assert property (@(posedge clk) disable iff (reset) // RULE_11
    1'b1 |=> (level_ff <= $past(ceil_lvl)))
    else $error("level above ceiling");

  a_no_overshoot: assert property (@(posedge clk) disable iff (reset) // RULE_14
    (state_ff == rgen_pkg::ST_RAMP && tick && enable && !decelerated_halt
     && level_ff < target_lvl) |=> (level_ff <= $past(target_lvl)))
    else $error("ramp overshot target");

  a_aq_zero: assert property (@(posedge clk) disable iff (reset) // RULE_08
    (level_ff <= offset_lvl) |=> (scaled_analog_out_ff == 16'h0000))
    else $error("scaled output not zero at offset");

  a_aq_range: assert property (@(posedge clk) disable iff (reset) // RULE_13
    1'b1 |=> (scaled_analog_out_ff <= rgen_pkg::AQ_MAX))
    else $error("scaled output out of range");

endmodule : rgen_ramp

// file: testbench/rgen_src_model.sv
`timescale 1ns/1ps

module rgen_src_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // values the upstream blocks are told to show
  input  wire logic [15:0] set_one,
  input  wire logic [15:0] set_two,
  // actual values handed to the ramp
  output logic [15:0]      ext_level_one,
  output logic [15:0]      ext_level_two
);

  // upstream blocks publish their actual value one clock after computing it
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_level_one <= 16'h0000;
      ext_level_two <= 16'h0000;
    end else begin
      ext_level_one <= set_one;
      ext_level_two <= set_two;
    end
  end

endmodule : rgen_src_model

// file: testbench/tb.sv
`timescale 1ns/1ps

module tb;
  typedef struct {logic [3:0] a; logic [15:0] d;} rgen_row_s;

  logic               clk;
  logic               reset;
  logic               enable;
  logic               level_sel;
  logic               decelerated_halt;
  logic [15:0]        set_one;
  logic [15:0]        set_two;
  logic [15:0]        ext_level_one;
  logic [15:0]        ext_level_two;
  logic [15:0]        rdata_ff;
  logic [15:0]        scaled_analog_out_ff;
  logic [15:0]        current_level_ff;
  logic [15:0]        rd_val;
  rgen_pkg::rgen_req_s req;
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 t0;
  rgen_row_s          rows [11] = '{
    '{rgen_pkg::A_TARGET_ONE, rgen_pkg::RST_TARGET_ONE},
    '{rgen_pkg::A_TARGET_TWO, rgen_pkg::RST_TARGET_TWO},
    '{rgen_pkg::A_CEILING, rgen_pkg::RST_CEILING},
    '{rgen_pkg::A_FLOOR_OFFSET, rgen_pkg::RST_FLOOR_OFFSET},
    '{rgen_pkg::A_RATE, rgen_pkg::RST_RATE},
    '{rgen_pkg::A_GAIN, rgen_pkg::RST_GAIN},
    '{rgen_pkg::A_OUT_OFFSET, rgen_pkg::RST_OUT_OFFSET},
    '{rgen_pkg::A_SOURCE, {14'h0000, rgen_pkg::RST_SOURCE}},
    '{rgen_pkg::A_LEVEL, 16'h0000},
    '{rgen_pkg::A_STATE, 16'h0001},
    '{4'hB, 16'h0000}};

  rgen_ramp #(.TICK_CYCLES(20)) rgen_ramp_inst (
    .clk(clk), .reset(reset), .enable(enable), .level_sel(level_sel),
    .decelerated_halt(decelerated_halt), .ext_level_one(ext_level_one),
    .ext_level_two(ext_level_two), .req(req), .rdata_ff(rdata_ff),
    .scaled_analog_out_ff(scaled_analog_out_ff), .current_level_ff(current_level_ff));

  rgen_src_model rgen_src_model_inst (
    .clk(clk), .reset(reset), .set_one(set_one), .set_two(set_two),
    .ext_level_one(ext_level_one), .ext_level_two(ext_level_two));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task test_done;
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      err_total++;
      test_done();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) req <= '0;
    #1 rd_val = rdata_ff;
  endtask : rd

  task wait_lvl(input logic [15:0] v);
    int n;
    n = 0;
    while (current_level_ff !== v && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(current_level_ff, v, "level not reached");
  endtask : wait_lvl

  task wait_chg;
    logic [15:0] v;
    int          n;
    v = current_level_ff;
    n = 0;
    while (current_level_ff === v && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_chg

  initial begin
    reset = 1'b1;
    enable = 1'b0;
    level_sel = 1'b0;
    decelerated_halt = 1'b0;
    req = '0;
    set_one = 16'h0000;
    set_two = 16'h012C;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(rd_val, rows[i].d, "register reset value");
    end
    rd(rgen_pkg::A_CEILING);
    @(posedge clk);
    #1 chk(rdata_ff, 16'h0000, "read data held too long");
    wr(4'hB, 16'h1234);
    rd(4'hB);
    chk(rd_val, 16'h0000, "unmapped read");
    wr(rgen_pkg::A_RATE, 16'h0000);
    rd(rgen_pkg::A_RATE);
    chk(rd_val, rgen_pkg::RATE_MIN, "rate low clamp");
    wr(rgen_pkg::A_RATE, 16'hFFFF);
    rd(rgen_pkg::A_RATE);
    chk(rd_val, rgen_pkg::RATE_MAX, "rate high clamp");
    wr(rgen_pkg::A_RATE, 16'h0064);
    wr(rgen_pkg::A_FLOOR_OFFSET, 16'h0064);
    wr(rgen_pkg::A_OUT_OFFSET, 16'h000A);
    wr(rgen_pkg::A_TARGET_ONE, 16'h00C8);
    wr(rgen_pkg::A_TARGET_TWO, 16'h0096);
    @(posedge clk) enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(current_level_ff, 16'h006E, "start floor");
    rd(rgen_pkg::A_STATE);
    chk(rd_val, 16'h0002, "start hold state");
    wait_chg();
    t0 = cyc;
    chk(current_level_ff, 16'h0078, "first step");
    wait_chg();
    chk(16'(cyc - t0), 16'h0014, "tick spacing");
    wait_lvl(16'h00C8);
    repeat (45) @(posedge clk);
    #1 chk(current_level_ff, 16'h00C8, "overshoot");
    chk(scaled_analog_out_ff, 16'h00BE, "scaled unity gain");
    rd(rgen_pkg::A_SCALED);
    chk(rd_val, 16'h00BE, "scaled register");
    wr(rgen_pkg::A_GAIN, 16'h00C8);
    repeat (3) @(posedge clk);
    #1 chk(scaled_analog_out_ff, 16'h005F, "scaled gain two");
    wr(rgen_pkg::A_GAIN, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk(scaled_analog_out_ff, rgen_pkg::AQ_MAX, "scaled gain zero");
    wr(rgen_pkg::A_GAIN, 16'h0064);
    @(posedge clk) level_sel <= 1'b1;
    wait_lvl(16'h0096);
    wr(rgen_pkg::A_CEILING, 16'h00A0);
    wr(rgen_pkg::A_SOURCE, 16'h0002);
    wait_lvl(16'h00A0);
    repeat (60) @(posedge clk);
    #1 chk(current_level_ff, 16'h00A0, "ceiling exceeded");
    @(posedge clk) decelerated_halt <= 1'b1;
    wait_lvl(16'h006E);
    t0 = cyc;
    wait_lvl(16'h000A);
    chk({15'h0000, (cyc - t0) inside {[20:22]}}, 16'h0001, "halt hold length");
    chk(scaled_analog_out_ff, 16'h0000, "scaled after halt");
    rd(rgen_pkg::A_STATE);
    chk(rd_val, 16'h0020, "locked state");
    @(posedge clk) enable <= 1'b0;
    repeat (3) @(posedge clk);
    enable <= 1'b1;
    repeat (30) @(posedge clk);
    #1 chk(current_level_ff, 16'h000A, "restart while halted");
    @(posedge clk) enable <= 1'b0;
    decelerated_halt <= 1'b0;
    rd(rgen_pkg::A_STATE);
    chk(rd_val, 16'h0001, "idle after both cleared");
    @(posedge clk) enable <= 1'b1;
    wait_lvl(16'h006E);
    wait_lvl(16'h0082);
    @(posedge clk) enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(current_level_ff, 16'h000A, "disable to offset");
    chk(scaled_analog_out_ff, 16'h0000, "scaled after disable");
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(rgen_pkg::A_CEILING);
    chk(rd_val, rgen_pkg::RST_CEILING, "ceiling after mid-run reset");
    chk(current_level_ff, 16'h0000, "level after mid-run reset");
    rd(rgen_pkg::A_STATE);
    chk(rd_val, 16'h0001, "state after mid-run reset");
    test_done();
  end

endmodule : tb
